// ---- rtl/timer_pkg.sv ----
// Constants for the sixteen-bit reload and capture timer
// Function
// [RL1] The counter and its companion register are sixteen bits, each read and written as two byte halves.
// [RL2] A run bit in the control register starts and stops the counter, which holds while stopped.
// [RL3] Control bits 7 to 5 select the mode, and codes 010 and 011 must not be programmed.
// [RL4] Codes 100 and 101 count down once per instruction cycle and reload from the companion on underflow.
// [RL5] In auto-reload mode each underflow raises the timer request, reaching the core only when enabled.
// [RL6] Code 101 inverts the timer pin on every underflow, while code 100 leaves the pin alone.
// [RL7] External counter mode counts pin edges, rising for code 000 and falling for code 001.
// [RL8] In external counter mode an underflow copies the companion into the counter and counting goes on.
// [RL9] In external counter mode each underflow raises the timer request, reaching the core only when enabled.
// [RL10] Capture mode counts every cycle and copies the count to the companion on the chosen pin edge.
// [RL11] In capture mode the chosen edge, not underflow, raises the timer request when enabled.
// [RL12] Software makes PWM by presetting the pin high and reloading on and off times at each interrupt.
// [RL13] Underflow and capture share one maskable timer interrupt source.
// [RL14] A timer pending flag is set by the interrupt condition and stays set until software clears it.
// [RL15] The instruction cycle runs at the input clock divided by ten.
// [RL16] The pin is synchronised and at most one qualifying edge per cycle is acted on.
// [RL17] Reset clears the control register, leaving the timer stopped in rising-edge counter mode.
package timer_pkg;
    localparam logic [3:0] ADDR_CNT_LO = 4'h0;
    localparam logic [3:0] ADDR_CNT_HI = 4'h1;
    localparam logic [3:0] ADDR_REL_LO = 4'h2;
    localparam logic [3:0] ADDR_REL_HI = 4'h3;
    localparam logic [3:0] ADDR_CTRL = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h5;
    localparam logic [3:0] ADDR_MASK = 4'h6;
    localparam logic [3:0] ADDR_PIN = 4'h7;
    localparam int MODE_HI = 7;
    localparam int MODE_LO = 5;
    localparam int RUN_BIT = 4;
    localparam int PEND_BIT = 0;
    localparam int PIN_LEVEL_BIT = 0;
    localparam int PIN_DRIVE_BIT = 1;
    localparam logic [2:0] MODE_EXT_RISE = 3'h0;
    localparam logic [2:0] MODE_EXT_FALL = 3'h1;
    localparam logic [2:0] MODE_AUTO = 3'h4;
    localparam logic [2:0] MODE_AUTO_TOG = 3'h5;
    localparam logic [2:0] MODE_CAP_RISE = 3'h6;
    localparam logic [2:0] MODE_CAP_FALL = 3'h7;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam int CLK_HZ = 100000000;
    localparam int INSTR_DIV = 10;
    localparam logic [3:0] DIV_LAST = 4'(INSTR_DIV - 1);
endpackage

// ---- rtl/timer_autoload_capture.sv ----
// Sixteen-bit down timer with reload, event count and capture modes
`timescale 1ns/1ps
module timer_autoload_capture
    import timer_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Register port
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    // Timer pin
    input wire logic timer_io_in,
    output logic timer_io_out,
    output logic timer_io_oe,
    // Interrupt
    output logic timer_irq
);
    logic [3:0] div_reg, div_next;
    logic tick_reg, tick_next;
    logic sync1_reg, sync2_reg, samp_reg, samp_next;
    logic [15:0] down_counter_reg, down_counter_next;
    logic [15:0] reload_capture_reg_reg, reload_capture_reg_next;
    logic [7:0] control_reg_reg, control_reg_next;
    logic timer_pending_flag_reg, timer_pending_flag_next;
    logic timer_irq_enable_reg, timer_irq_enable_next;
    logic [1:0] pin_reg, pin_next;
    logic [7:0] rdata_reg, rdata_next;
    logic irq_reg, irq_next;
    logic oe_reg, oe_next;
    logic [2:0] mode;
    logic run, rise, fall, edge_hit, timed, ext, cap;
    logic dec, uflow, capture, event_hit;

    assign mode = control_reg_reg[MODE_HI:MODE_LO];
    assign run = control_reg_reg[RUN_BIT];

    // Instruction cycle strobe, registered so it is clean
    always_comb
    begin
        div_next = (div_reg == DIV_LAST) ? 4'h0 : div_reg + 4'h1; // RL15
        tick_next = (div_reg == DIV_LAST); // RL15
    end

    // Pin edges are judged only at the instruction strobe
    always_comb
    begin
        samp_next = tick_reg ? sync2_reg : samp_reg; // RL16
        rise = tick_reg && sync2_reg && !samp_reg; // RL16
        fall = tick_reg && !sync2_reg && samp_reg; // RL16
        edge_hit = mode[0] ? fall : rise; // RL7 RL10
        timed = (mode == MODE_AUTO) || (mode == MODE_AUTO_TOG) ||
            (mode == MODE_CAP_RISE) || (mode == MODE_CAP_FALL);
        ext = (mode == MODE_EXT_RISE) || (mode == MODE_EXT_FALL);
        cap = (mode == MODE_CAP_RISE) || (mode == MODE_CAP_FALL);
    end

    // Counter, companion and pin; codes 010 and 011 leave all idle
    always_comb
    begin
        dec = run && ((timed && tick_reg) || (ext && edge_hit)); // RL2 RL3
        uflow = dec && (down_counter_reg == CNT_RESET);
        capture = run && cap && edge_hit; // RL10
        event_hit = cap ? capture : uflow; // RL5 RL9 RL11 RL13
        down_counter_next = down_counter_reg;
        reload_capture_reg_next = reload_capture_reg_reg;
        pin_next = pin_reg;
        if (dec)
        begin
            if (uflow && !cap)
            begin
                down_counter_next = reload_capture_reg_reg; // RL4 RL8
            end
            else
            begin
                down_counter_next = down_counter_reg - 16'h0001; // RL4 RL10
            end
        end
        if (capture)
        begin
            reload_capture_reg_next = down_counter_reg; // RL10
        end
        if (uflow && mode == MODE_AUTO_TOG)
        begin
            pin_next[PIN_LEVEL_BIT] = !pin_reg[PIN_LEVEL_BIT]; // RL6
        end
        // Software writes win over the hardware update
        if (wr_en)
        begin
            case (addr)
                ADDR_CNT_LO: down_counter_next[7:0] = wdata; // RL1
                ADDR_CNT_HI: down_counter_next[15:8] = wdata; // RL1
                ADDR_REL_LO: reload_capture_reg_next[7:0] = wdata; // RL1
                ADDR_REL_HI: reload_capture_reg_next[15:8] = wdata; // RL1
                ADDR_PIN: pin_next = wdata[1:0];
                default: pin_next = pin_next;
            endcase
        end
    end

    // Control, pending flag and enable; a new event beats the clear
    always_comb
    begin
        control_reg_next = control_reg_reg;
        timer_irq_enable_next = timer_irq_enable_reg;
        timer_pending_flag_next = timer_pending_flag_reg;
        if (wr_en && addr == ADDR_CTRL)
        begin
            control_reg_next = wdata; // RL2 RL3
        end
        if (wr_en && addr == ADDR_MASK)
        begin
            timer_irq_enable_next = wdata[PEND_BIT]; // RL13
        end
        if (wr_en && addr == ADDR_STATUS && wdata[PEND_BIT])
        begin
            timer_pending_flag_next = 1'b0; // RL14
        end
        if (event_hit)
        begin
            timer_pending_flag_next = 1'b1; // RL14
        end
        irq_next = timer_pending_flag_next && timer_irq_enable_next; // RL13
        oe_next = pin_next[PIN_DRIVE_BIT] || (mode == MODE_AUTO_TOG);
        if (wr_en && addr == ADDR_CTRL)
        begin
            oe_next = pin_next[PIN_DRIVE_BIT] ||
                (wdata[MODE_HI:MODE_LO] == MODE_AUTO_TOG);
        end
    end

    // Read data stand only in the cycle after the strobe
    always_comb
    begin
        rdata_next = BYTE_ZERO;
        if (rd_en)
        begin
            case (addr)
                ADDR_CNT_LO: rdata_next = down_counter_reg[7:0]; // RL1
                ADDR_CNT_HI: rdata_next = down_counter_reg[15:8]; // RL1
                ADDR_REL_LO: rdata_next = reload_capture_reg_reg[7:0];
                ADDR_REL_HI: rdata_next = reload_capture_reg_reg[15:8];
                ADDR_CTRL: rdata_next = control_reg_reg;
                ADDR_STATUS: rdata_next = {7'h00, timer_pending_flag_reg};
                ADDR_MASK: rdata_next = {7'h00, timer_irq_enable_reg};
                ADDR_PIN: rdata_next = {6'h00, pin_reg};
                default: rdata_next = BYTE_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            div_reg <= 4'h0;
            tick_reg <= 1'b0;
        end
        else
        begin
            div_reg <= div_next;
            tick_reg <= tick_next;
        end
    end

    // Only the second flop reads the first, so metastability stays there
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            samp_reg <= 1'b0;
        end
        else
        begin
            sync1_reg <= timer_io_in; // RL16
            sync2_reg <= sync1_reg; // RL16
            samp_reg <= samp_next;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            down_counter_reg <= CNT_RESET;
            reload_capture_reg_reg <= CNT_RESET;
            pin_reg <= 2'h0;
        end
        else
        begin
            down_counter_reg <= down_counter_next;
            reload_capture_reg_reg <= reload_capture_reg_next;
            pin_reg <= pin_next;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            control_reg_reg <= CTRL_RESET; // RL17
            timer_pending_flag_reg <= 1'b0;
            timer_irq_enable_reg <= 1'b0;
            irq_reg <= 1'b0;
            oe_reg <= 1'b0;
        end
        else
        begin
            control_reg_reg <= control_reg_next;
            timer_pending_flag_reg <= timer_pending_flag_next;
            timer_irq_enable_reg <= timer_irq_enable_next;
            irq_reg <= irq_next;
            oe_reg <= oe_next;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rdata_reg <= BYTE_ZERO;
        end
        else
        begin
            rdata_reg <= rdata_next;
        end
    end

    assign rdata = rdata_reg;
    assign timer_io_out = pin_reg[PIN_LEVEL_BIT];
    assign timer_io_oe = oe_reg;
    assign timer_irq = irq_reg;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    a_tick_period: assert property ( // RL15
        tick_reg |=> !tick_reg [*8] ##1 !tick_reg ##1 tick_reg)
        else $error("instruction strobe not every ten clocks");
    a_stop_hold: assert property ( // RL2
        !run && !wr_en |=> $stable(down_counter_reg))
        else $error("stopped counter moved");
    a_auto_decr: assert property ( // RL4
        run && tick_reg && mode == MODE_AUTO && !wr_en &&
        down_counter_reg != CNT_RESET
        |=> down_counter_reg == $past(down_counter_reg) - 16'h0001)
        else $error("auto mode did not decrement");
    a_auto_reload: assert property ( // RL4
        run && tick_reg && mode[2:1] == 2'h2 && !wr_en &&
        down_counter_reg == CNT_RESET
        |=> down_counter_reg == $past(reload_capture_reg_reg))
        else $error("underflow did not reload");
    a_pin_toggle: assert property ( // RL6
        uflow && mode == MODE_AUTO_TOG && !wr_en
        |=> timer_io_out != $past(timer_io_out))
        else $error("pin not toggled on underflow");
    a_capture_copy: assert property ( // RL10
        capture && !wr_en
        |=> reload_capture_reg_reg == $past(down_counter_reg))
        else $error("capture missed the count");
    a_pending_set: assert property ( // RL14
        event_hit ##1 !(wr_en && addr == ADDR_STATUS && wdata[PEND_BIT])
        |-> timer_pending_flag_reg ##1 (irq_reg || !timer_irq_enable_reg))
        else $error("event did not set pending flag");
    a_irq_level: assert property ( // RL13
        timer_pending_flag_reg && timer_irq_enable_reg |-> timer_irq)
        else $error("interrupt low while pending and enabled");
    a_ext_quiet: assert property ( // RL7
        ext && !edge_hit && !wr_en |=> $stable(down_counter_reg))
        else $error("counter moved without a pin edge");
    a_ext_decr: assert property ( // RL7
        ext && dec && !uflow && !wr_en
        |=> down_counter_reg == $past(down_counter_reg) - 16'h0001)
        else $error("external edge did not decrement");
    a_ext_reload: assert property ( // RL8
        ext && uflow && !wr_en
        |=> down_counter_reg == $past(reload_capture_reg_reg))
        else $error("external underflow did not reload");
    a_bad_mode: assert property ( // RL3
        mode[2:1] == 2'h1 && !wr_en
        |=> $stable(down_counter_reg) && $stable(reload_capture_reg_reg))
        else $error("forbidden mode changed the timer");
    a_no_toggle: assert property ( // RL6
        mode != MODE_AUTO_TOG && !wr_en |=> $stable(timer_io_out))
        else $error("pin moved outside toggle mode");
    a_toggle_drive: assert property ( // RL6
        mode == MODE_AUTO_TOG && !wr_en |=> timer_io_oe)
        else $error("pin not driven in toggle mode");
    a_cap_wrap: assert property ( // RL10
        run && cap && tick_reg && !wr_en && down_counter_reg == CNT_RESET
        |=> down_counter_reg == 16'hffff)
        else $error("capture mode did not wrap");
    a_cap_event: assert property ( // RL11
        cap && !edge_hit && !timer_pending_flag_reg
        |=> !timer_pending_flag_reg)
        else $error("capture mode raised flag without an edge");
    a_set_wins: assert property ( // RL14
        event_hit && wr_en && addr == ADDR_STATUS |=> timer_pending_flag_reg)
        else $error("clear beat a new event");
    a_pend_hold: assert property ( // RL14
        timer_pending_flag_reg && !(wr_en && addr == ADDR_STATUS)
        |=> timer_pending_flag_reg)
        else $error("pending flag dropped without a clear");
    a_stop_capture: assert property ( // RL2
        !run && !wr_en |=> $stable(reload_capture_reg_reg))
        else $error("stopped timer captured");
    a_read_idle: assert property ( // RL1
        !rd_en |=> rdata == BYTE_ZERO)
        else $error("read data stood outside its cycle");
endmodule

// ---- tb/timer_pin_model.sv ----
// Event source driving the timer pin from outside
`timescale 1ns/1ps
module timer_pin_model (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Burst request
    input wire logic go,
    input wire logic [7:0] n_pulse,
    input wire logic [7:0] half,
    // Pin side
    output logic level,
    output logic busy
);
    logic [8:0] left;
    logic [7:0] cnt;
    // Half periods stay well above one instruction cycle so no edge is lost
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            level <= 1'b0;
            busy <= 1'b0;
            left <= 9'h000;
            cnt <= 8'h00;
        end
        else if (go && !busy)
        begin
            busy <= 1'b1;
            left <= {n_pulse, 1'b0};
            cnt <= 8'h00;
        end
        else if (busy && cnt == half - 8'h01)
        begin
            cnt <= 8'h00;
            level <= ~level;
            left <= left - 9'h001;
            busy <= (left != 9'h001);
        end
        else if (busy)
            cnt <= cnt + 8'h01;
    end
endmodule

// ---- tb/timer_autoload_capture_tb_top.sv ----
// Self-checking bench for the reload and capture timer
`timescale 1ns/1ps
module timer_autoload_capture_tb_top
    import timer_pkg::*;
;
    logic clk, resetn, wr_en, rd_en, go, irq, o_out, oe, lvl, busy;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, n_pulse, half, b;
    logic [15:0] v, c, r;
    int n_mismatch = 0;
    int tests_run = 0;
    int i, n;
    time t0;
    wire pin = oe ? o_out : lvl;
    timer_autoload_capture i_dut (.clk(clk), .resetn(resetn), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .timer_io_in(pin), .timer_io_out(o_out), .timer_io_oe(oe),
        .timer_irq(irq));
    timer_pin_model i_pin (.clk(clk), .resetn(resetn), .go(go),
        .n_pulse(n_pulse), .half(half), .level(lvl), .busy(busy));
    function automatic logic [7:0] ctl(input logic [2:0] m, input logic run);
        return {m, run, 4'h0};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic w16(input logic [3:0] a, input logic [15:0] d);
        wr(a, d[7:0]);
        wr(a + 4'h1, d[15:8]);
    endtask
    task automatic r16(input logic [3:0] a, output logic [15:0] d);
        rd(a, d[7:0]);
        rd(a + 4'h1, d[15:8]);
    endtask
    // Pending clear, then room for the level output to fall
    task automatic clr;
        wr(ADDR_STATUS, 8'h01);
        repeat (3) @(posedge clk);
    endtask
    task automatic wirq;
        int k;
        k = 0;
        #1;
        while (irq !== 1'b1 && k < 5000)
        begin
            @(posedge clk);
            #1 k++;
        end
        chk(16'(irq), 16'h0001);
    endtask
    task automatic pulse(input int np, input int h);
        int k;
        k = 0;
        @(posedge clk);
        go <= 1'b1;
        n_pulse <= 8'(np);
        half <= 8'(h);
        @(posedge clk);
        go <= 1'b0;
        #1;
        while (busy && k < 5000)
        begin
            @(posedge clk);
            #1 k++;
        end
        repeat (30) @(posedge clk);
    endtask
    task automatic final_report;
        if (n_mismatch == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        #200000;
        n_mismatch++;
        final_report;
    end
    initial
    begin
        resetn = 1'b0;
        {addr, wdata, wr_en, rd_en, go, n_pulse, half} = '0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        v = 16'($urandom(42));
        rd(ADDR_CTRL, b);
        chk(16'(b), 16'(CTRL_RESET));
        rd(4'h8, b);
        chk(16'(b), 16'h0000);
        wr(ADDR_CTRL, ctl(MODE_AUTO, 1'b0));
        v = 16'($urandom);
        r = 16'($urandom);
        w16(ADDR_CNT_LO, v);
        w16(ADDR_REL_LO, r);
        repeat (100) @(posedge clk);
        r16(ADDR_CNT_LO, c);
        chk(c, v);
        r16(ADDR_REL_LO, c);
        chk(c, r);
        r = 16'($urandom_range(20, 2));
        w16(ADDR_CNT_LO, r);
        w16(ADDR_REL_LO, r);
        wr(ADDR_MASK, 8'h01);
        wr(ADDR_CTRL, ctl(MODE_AUTO, 1'b1));
        wirq;
        t0 = $time;
        clr;
        wirq;
        chk(16'($time - t0), 16'((r + 1) * INSTR_DIV * 10));
        rd(ADDR_STATUS, b);
        chk(16'(b[PEND_BIT]), 16'h0001);
        chk(16'(o_out), 16'h0000);
        clr;
        chk(16'(irq), 16'h0000);
        wr(ADDR_MASK, 8'h00);
        repeat ((r + 2) * INSTR_DIV) @(posedge clk);
        rd(ADDR_STATUS, b);
        chk(16'({b[PEND_BIT], irq}), 16'h0002);
        // Stop first so no stray underflow lands after the clear
        wr(ADDR_CTRL, 8'h00);
        // Pin preset high before toggling starts, as for PWM
        wr(ADDR_PIN, 8'h01);
        wr(ADDR_MASK, 8'h01);
        clr;
        wr(ADDR_CTRL, ctl(MODE_AUTO_TOG, 1'b1));
        for (i = 0; i < 3; i++)
        begin
            b[0] = o_out;
            wirq;
            chk(16'({oe, o_out}), 16'({1'b1, ~b[0]}));
            clr;
        end
        wr(ADDR_CTRL, ctl(MODE_AUTO_TOG, 1'b0));
        wr(ADDR_PIN, 8'h00);
        wr(ADDR_CTRL, 8'h00);
        for (i = 0; i < 2; i++)
        begin
            n = $urandom_range(8, 1);
            r = 16'($urandom);
            w16(ADDR_CNT_LO, 16'(n - 1));
            w16(ADDR_REL_LO, r);
            clr;
            wr(ADDR_CTRL, ctl(i ? MODE_EXT_FALL : MODE_EXT_RISE, 1'b1));
            pulse(n, 15);
            chk(16'(irq), 16'h0001);
            wr(ADDR_CTRL, 8'h00);
            r16(ADDR_CNT_LO, c);
            chk(c, r);
        end
        for (i = 0; i < 2; i++)
        begin
            w16(ADDR_CNT_LO, 16'hffff);
            w16(ADDR_REL_LO, 16'h0000);
            clr;
            wr(ADDR_CTRL, ctl(i ? MODE_CAP_FALL : MODE_CAP_RISE, 1'b1));
            pulse(1, 100);
            chk(16'(irq), 16'h0001);
            wr(ADDR_CTRL, 8'h00);
            r16(ADDR_CNT_LO, c);
            r16(ADDR_REL_LO, r);
            chk(16'(r != 0 && ((r - c > 7) == (i == 0))), 16'h0001);
        end
        for (i = 2; i < 4; i++)
        begin
            w16(ADDR_CNT_LO, 16'h0005);
            clr;
            wr(ADDR_CTRL, ctl(3'(i), 1'b1));
            repeat (100) @(posedge clk);
            pulse(2, 15);
            wr(ADDR_CTRL, 8'h00);
            r16(ADDR_CNT_LO, c);
            rd(ADDR_STATUS, b);
            chk({c[14:0], b[PEND_BIT]}, 16'h000a);
        end
        final_report;
    end
endmodule
